// ===== rtl/idr_top.sv
`timescale 1ns/100ps
`include "idr_regs.svh"

module idr_top (
   // Clock and reset
   input  wire logic                              clock,
   input  wire logic                              rst_b,
   // Parameter settings
   input  wire logic                              proc_irq_enable,
   input  wire logic                              diag_irq_enable,
   // Limit underflow conditions per channel
   input  wire logic [1:0]                        underflow_pin,
   // Diagnostic conditions per channel and record content
   input  wire logic [1:0]                        diag_cond_pin,
   input  wire logic [`IDR_INFO_BYTES-1:0][7:0]   diag_info,
   // Process interrupt
   output logic                                   proc_irq,
   output logic [7:0]                             limit_underflow_flags,
   output logic [15:0]                            interrupt_timestamp,
   // Diagnostic interrupt
   output logic                                   diag_irq_incoming,
   output logic                                   diag_irq_going,
   output logic                                   fault_indicator,
   // Record read port
   input  wire idr_pkg::idr_rd_req_s              rd_req,
   output idr_pkg::idr_rd_ans_s                   rd_ans
);

   localparam logic [3:0] TICK_LAST = 4'(`IDR_TICK_CYCLES - 1);

   idr_pkg::idr_state_s st;
   idr_pkg::idr_state_s next_st;
   idr_pkg::idr_chan_s  chan [2];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_chan
         idr_chan u_chan (
            .clock    (clock),
            .rst_b    (rst_b),
            .cond_pin (diag_cond_pin[g]),
            .enable   (diag_irq_enable),
            .chan     (chan[g])
         );
      end
   endgenerate

   assign proc_irq              = st.proc_irq;
   assign limit_underflow_flags = st.flags;
   assign interrupt_timestamp   = st.stamp;
   assign diag_irq_incoming     = st.diag_in;
   assign diag_irq_going        = st.diag_go;
   assign fault_indicator       = st.fault;
   assign rd_ans                = st.ans;

   always_comb begin
      logic [1:0]  ul_edge;
      logic        any_in;
      logic        any_go;
      logic        full_sel;
      logic        short_sel;
      logic [4:0]  len;
      ul_edge   = 2'h0;
      any_in    = 1'b0;
      any_go    = 1'b0;
      full_sel  = 1'b0;
      short_sel = 1'b0;
      len       = 5'h00;
      next_st   = st;

      // Ticker: a prescaler gives one count per microsecond.
      if (st.prescale == TICK_LAST) begin
         next_st.prescale = 4'h0;
         next_st.ticker   = st.ticker + 32'h0000_0001;
      end else begin
         next_st.prescale = st.prescale + 4'h1;
      end

      // Process interrupt on a rising underflow condition.
      next_st.ul_meta  = underflow_pin;
      next_st.ul_sync  = st.ul_meta;
      next_st.ul_prev  = st.ul_sync;
      ul_edge          = st.ul_sync & ~st.ul_prev;
      next_st.proc_irq = 1'b0;
      if (proc_irq_enable && (ul_edge != 2'h0)) begin
         next_st.proc_irq                 = 1'b1;
         next_st.flags                    = `IDR_UL_RESET;
         next_st.flags[`IDR_UL_CH0_BIT]   = ul_edge[0];
         next_st.flags[`IDR_UL_CH1_BIT]   = ul_edge[1];
         next_st.stamp                    = st.ticker[15:0];
      end

      // Diagnostic interrupts collected from both channels.
      any_in          = chan[0].incoming | chan[1].incoming;
      any_go          = chan[0].going | chan[1].going;
      next_st.diag_in = any_in;
      next_st.diag_go = any_go;
      next_st.fault   = (chan[0].st == idr_pkg::chan_raised) ||
                        (chan[1].st == idr_pkg::chan_raised);
      if (any_in || any_go) begin
         for (int i = 0; i < `IDR_INFO_BYTES; i++) begin
            next_st.rec[i] = diag_info[i];
         end
         for (int i = 0; i < 4; i++) begin
            next_st.rec[`IDR_INFO_BYTES + i] = st.ticker[8*i +: 8];
         end
      end

      // Record reads, answered one cycle after the request.
      next_st.ans = '{ack: 1'b0, err: 1'b0, data: 8'h00, len: 5'h00};
      if (rd_req.req) begin
         if (rd_req.by_index) begin
            full_sel  = (rd_req.select == `IDR_IX_FULL);
            short_sel = (rd_req.select == `IDR_IX_SHORT);
         end else begin
            full_sel  = (rd_req.select == `IDR_REC_FULL);
            short_sel = (rd_req.select == `IDR_REC_SHORT);
         end
         if (full_sel) begin
            len = `IDR_FULL_LEN;
         end else if (short_sel) begin
            len = `IDR_SHORT_LEN;
         end else begin
            len = 5'h00;
         end
         next_st.ans.ack = 1'b1;
         next_st.ans.len = len;
         if (rd_req.offset < len) begin
            next_st.ans.data = st.rec[rd_req.offset];
         end else begin
            next_st.ans.err = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule

// ===== rtl/idr_regs.svh
`ifndef IDR_REGS_SVH
`define IDR_REGS_SVH

// Ticker timing: one count per microsecond from a 100 ns clock.
`define IDR_TICK_NS      1000
`define IDR_CLK_NS       100
`define IDR_TICK_CYCLES  ((`IDR_TICK_NS + `IDR_CLK_NS - 1) / `IDR_CLK_NS)

// Process interrupt fields.
`define IDR_UL_CH0_BIT   0
`define IDR_UL_CH1_BIT   1
`define IDR_UL_RESET     8'h00
`define IDR_STAMP_RESET  16'h0000
`define IDR_TICK_RESET   32'h0000_0000

// Diagnostic record selectors.
`define IDR_REC_FULL     16'h0001
`define IDR_REC_SHORT    16'h0000
`define IDR_IX_FULL      16'h2F01
`define IDR_IX_SHORT     16'h2F00

// Diagnostic record layout: content bytes from outside, then the 32-bit ticker.
`define IDR_INFO_BYTES   16
`define IDR_REC_BYTES    20
`define IDR_FULL_LEN     5'h14
`define IDR_SHORT_LEN    5'h04

`endif

// ===== rtl/idr_pkg.sv
package idr_pkg;

   typedef enum logic [0:0] {
      chan_clear,
      chan_raised
   } idr_chan_e;

   typedef struct packed {
      logic [1:0] meta;
      idr_chan_e  st;
      logic       incoming;
      logic       going;
   } idr_chan_s;

   typedef struct packed {
      logic        req;
      logic        by_index;
      logic [15:0] select;
      logic [4:0]  offset;
   } idr_rd_req_s;

   typedef struct packed {
      logic       ack;
      logic       err;
      logic [7:0] data;
      logic [4:0] len;
   } idr_rd_ans_s;

   typedef struct packed {
      logic [3:0]        prescale;
      logic [31:0]       ticker;
      logic [1:0]        ul_meta;
      logic [1:0]        ul_sync;
      logic [1:0]        ul_prev;
      logic [7:0]        flags;
      logic [15:0]       stamp;
      logic              proc_irq;
      logic              diag_in;
      logic              diag_go;
      logic              fault;
      logic [19:0][7:0]  rec;
      idr_rd_ans_s       ans;
   } idr_state_s;

endpackage

// ===== rtl/idr_chan.sv
`timescale 1ns/100ps
`include "idr_regs.svh"

// Tracks one channel's diagnostic condition between incoming and going.
module idr_chan (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_b,
   // Condition pin and enable from parameter settings
   input  wire logic             cond_pin,
   input  wire logic             enable,
   // Channel state
   output idr_pkg::idr_chan_s    chan
);

   idr_pkg::idr_chan_s st;
   idr_pkg::idr_chan_s next_st;
   logic               cond;

   assign cond = st.meta[1];
   assign chan = st;

   always_comb begin
      next_st          = st;
      next_st.meta     = {st.meta[0], cond_pin};
      next_st.incoming = 1'b0;
      next_st.going    = 1'b0;
      case (st.st)
         idr_pkg::chan_clear: begin
            if (cond && enable) begin
               next_st.st       = idr_pkg::chan_raised;
               next_st.incoming = 1'b1;
            end
         end
         idr_pkg::chan_raised: begin
            // Any further change while raised is dropped; only the clearing counts.
            if (!cond) begin
               next_st.st    = idr_pkg::chan_clear;
               next_st.going = 1'b1;
            end
         end
         default: next_st.st = idr_pkg::chan_clear;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st <= '{meta: 2'h0, st: idr_pkg::chan_clear, incoming: 1'b0, going: 1'b0};
      end else begin
         st <= next_st;
      end
   end

endmodule

// ===== tb/idr_chk.sv
`timescale 1ns/100ps
`include "idr_regs.svh"
module idr_chk (
   // Clock and reset
   input wire logic                 clock,
   input wire logic                 rst_b,
   // Watched ports
   input wire logic                 proc_irq_enable,
   input wire logic                 diag_irq_enable,
   input wire logic                 proc_irq,
   input wire logic [7:0]           limit_underflow_flags,
   input wire logic [15:0]          interrupt_timestamp,
   input wire logic                 diag_irq_incoming,
   input wire logic                 diag_irq_going,
   input wire logic                 fault_indicator,
   input wire idr_pkg::idr_rd_req_s rd_req,
   input wire idr_pkg::idr_rd_ans_s rd_ans
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   AST_UL_RSV: assert property (limit_underflow_flags[7:2] == 6'h00) else $error("flags");
   AST_UL_CAUSE: assert property (proc_irq |-> limit_underflow_flags[1:0] != 2'h0)
      else $error("empty flags");
   AST_PROC_EN: assert property (proc_irq |-> $past(proc_irq_enable)) else $error("irq off");
   AST_STAMP_HOLD: assert property (!proc_irq |-> $stable(interrupt_timestamp))
      else $error("stamp moved");
   AST_DIAG_EN: assert property (diag_irq_incoming |-> $past(diag_irq_enable, 2))
      else $error("diag off");
   AST_FAULT_ON: assert property (diag_irq_incoming |-> fault_indicator) else $error("no fault");
   AST_FAULT_OFF: assert property ($fell(fault_indicator) |-> diag_irq_going)
      else $error("fault off");
   AST_ACK: assert property (rd_req.req |=> rd_ans.ack) else $error("no ack");
   AST_FULL: assert property (rd_req.req && rd_req.select == (rd_req.by_index ?
      `IDR_IX_FULL : `IDR_REC_FULL) |=> rd_ans.len == `IDR_FULL_LEN) else $error("len");
   cover property (proc_irq);
   cover property (diag_irq_going && !fault_indicator);
   cover property (rd_ans.ack && rd_ans.err);
endmodule

bind idr_top idr_chk chk_u (.*);

// ===== tb/idr_coupler.sv
`timescale 1ns/100ps
// Coupler side of the record read port; one byte per read.
module idr_coupler (
   // Clock
   input wire logic                 clock,
   // Record read port
   output idr_pkg::idr_rd_req_s     rd_req,
   input wire idr_pkg::idr_rd_ans_s rd_ans
);
   initial rd_req = '0;
   task automatic read(input logic bi, input logic [15:0] sel, input logic [4:0] off,
                       output idr_pkg::idr_rd_ans_s ans);
      @(negedge clock);
      rd_req = '{1'b1, bi, sel, off};
      @(negedge clock);
      ans = rd_ans;
      rd_req = '0;
   endtask
endmodule

// ===== tb/interrupt_timestamp_diag_report_tb.sv
`timescale 1ns/100ps
module interrupt_timestamp_diag_report_tb;
   logic                       clock = 1'b0;
   logic                       rst_b = 1'b0;
   logic                       proc_irq_enable = 1'b0;
   logic                       diag_irq_enable = 1'b0;
   logic [1:0]                 underflow_pin = 2'h0;
   logic [1:0]                 diag_cond_pin = 2'h0;
   logic [15:0][7:0]           diag_info = '0;
   logic                       proc_irq, diag_irq_incoming, diag_irq_going, fault_indicator;
   logic [7:0]                 limit_underflow_flags;
   logic [15:0]                interrupt_timestamp;
   idr_pkg::idr_rd_req_s       rd_req;
   idr_pkg::idr_rd_ans_s       rd_ans, ans;
   int                         err_count = 0, n_checks = 0;
   int                         irq_cnt = 0, inc_cnt = 0, go_cnt = 0;
   idr_top dut_u (.*);
   idr_coupler coupler_u (.clock(clock), .rd_req(rd_req), .rd_ans(rd_ans));
   always #50 clock = ~clock;
   always @(posedge clock) begin
      irq_cnt <= irq_cnt + int'(proc_irq === 1'b1);
      inc_cnt <= inc_cnt + int'(diag_irq_incoming === 1'b1);
      go_cnt <= go_cnt + int'(diag_irq_going === 1'b1);
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic rd(input logic bi, input logic [15:0] sel, input logic [4:0] off,
                     input logic e, input logic [7:0] d, input logic [4:0] l);
      coupler_u.read(bi, sel, off, ans);
      chk({ans.ack, ans.err, ans.data, ans.len}, {1'b1, e, d, l});
   endtask
   // Events 300 cycles apart make the stamp gap independent of the reset release delay.
   task automatic t_proc;
      logic [15:0] s0;
      proc_irq_enable = 1'b1;
      underflow_pin = 2'h1;
      idle(150);
      chk(limit_underflow_flags, 8'h01);
      s0 = interrupt_timestamp;
      chk(s0, 16'h0000);
      underflow_pin = 2'h0;
      idle(150);
      underflow_pin = 2'h3;
      idle(150);
      chk(limit_underflow_flags, 8'h03);
      chk(16'(interrupt_timestamp - s0), 16'h001E);
      proc_irq_enable = 1'b0;
      underflow_pin = 2'h0;
      idle(10);
      underflow_pin = 2'h2;
      idle(10);
      chk(irq_cnt, 2);
      chk(limit_underflow_flags, 8'h03);
   endtask
   task automatic t_diag;
      diag_info = {16{8'hA5}};
      diag_cond_pin = 2'h1;
      idle(20);
      chk(inc_cnt, 0);
      diag_cond_pin = 2'h0;
      idle(5);
      diag_irq_enable = 1'b1;
      diag_cond_pin = 2'h1;
      idle(10);
      chk(fault_indicator, 1'b1);
      diag_info = {16{8'h5A}};
      idle(10);
      rd(1'b0, 16'h0001, 5'h00, 1'b0, 8'hA5, 5'h14);
      diag_cond_pin = 2'h3;
      idle(10);
      diag_cond_pin = 2'h2;
      idle(10);
      chk(fault_indicator, 1'b1);
      diag_cond_pin = 2'h0;
      idle(10);
      chk(fault_indicator, 1'b0);
      chk(go_cnt, 2);
      chk(inc_cnt, 2);
   endtask
   task automatic t_read;
      rd(1'b0, 16'h0001, 5'h13, 1'b0, 8'h00, 5'h14);
      rd(1'b1, 16'h2F01, 5'h0F, 1'b0, 8'h5A, 5'h14);
      rd(1'b0, 16'h0000, 5'h03, 1'b0, 8'h5A, 5'h04);
      rd(1'b1, 16'h2F00, 5'h03, 1'b0, 8'h5A, 5'h04);
      rd(1'b0, 16'h0000, 5'h04, 1'b1, 8'h00, 5'h04);
      rd(1'b1, 16'h0001, 5'h00, 1'b1, 8'h00, 5'h00);
   endtask
   task automatic summarize;
      if (err_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      idle(10);
      rst_b = 1'b1;
      t_proc();
      t_diag();
      t_read();
      summarize();
   end
   initial begin
      #(5000 * 100);
      err_count++;
      summarize();
   end
endmodule
